/* File: bridge_drive_map.svh */
// Purpose: constants for the dual bridge drive control
// Assumes: 20 MHz clock, 50 ns period
// Notes: times are kept in their own unit, cycle counts derived from them
`ifndef BRIDGE_DRIVE_MAP_SVH
`define BRIDGE_DRIVE_MAP_SVH

`define CLK_HZ 20000000
`define SLEEP_ENTRY_TIME_US 1000
`define FAULT_FILTER_TIME_NS 2000
`define RETRY_LOCKOUT_TIME_US 2000
// longer than 1 ms: least time, rounded up
`define SLEEP_CYCLES ((`SLEEP_ENTRY_TIME_US * (`CLK_HZ / 1000000)))
// longer than 2 us: least time, rounded up
`define FILTER_CYCLES ((`FAULT_FILTER_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define LOCKOUT_CYCLES ((`RETRY_LOCKOUT_TIME_US * (`CLK_HZ / 1000000)))
`define CNT_W 16
`define FLT_CNT_W 6

`endif

/* File: bridge_drive_pkg.sv */
// Purpose: types for the dual bridge drive control
// Assumes: nothing beyond the map header
// Notes: gate commands travel as a packed struct per bridge
package bridge_drive_pkg;

  typedef enum logic [1:0] {
    DRV_OFF  = 2'b00,
    DRV_HIGH = 2'b01,
    DRV_LOW  = 2'b10
  } drv_level_t;

  // gate enables of one full bridge
  typedef struct packed {
    logic src_p;
    logic snk_p;
    logic src_n;
    logic snk_n;
  } bridge_gates_t;

  typedef enum logic [1:0] {
    CH_RUN     = 2'b00,
    CH_FILTER  = 2'b01,
    CH_LOCKOUT = 2'b10
  } ch_state_t;

  typedef struct packed {
    ch_state_t state;
    logic [5:0] filt;
    logic [15:0] lock;
  } ch_state_s_t;

  typedef struct packed {
    logic asleep;
    logic [15:0] idle;
    bridge_gates_t gates_a;
    bridge_gates_t gates_b;
  } top_state_t;

endpackage : bridge_drive_pkg

/* File: bridge_fault_channel.sv */
// Purpose: per-bridge overcurrent filter and retry lockout
// Assumes: fault indications are synchronous to clk
// Notes: one instance per bridge so channels are independent
`timescale 1ns/100ps
`include "bridge_drive_map.svh"

module bridge_fault_channel
  import bridge_drive_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic src_on,
  input wire logic snk_on,
  input wire logic src_overcurrent,
  input wire logic snk_overvoltage,
  output logic bridge_blocked,
  output logic fault_pulse
);

  ch_state_s_t s_q;
  ch_state_s_t s_d;
  logic cond;

  // only indications from drivers actually turned on count
  assign cond = (src_on && src_overcurrent) || (snk_on && snk_overvoltage);

  always_comb begin
    s_d = s_q;
    fault_pulse = 1'b0;
    case (s_q.state)
      CH_RUN: begin
        s_d.filt = '0;
        if (cond) begin
          s_d.state = CH_FILTER;
          s_d.filt = 6'h01;
        end
      end
      CH_FILTER: begin
        if (!cond) begin
          s_d.state = CH_RUN;
          s_d.filt = '0;
        end else if (s_q.filt >= `FLT_CNT_W'(`FILTER_CYCLES)) begin
          s_d.state = CH_LOCKOUT;
          s_d.lock = '0;
          fault_pulse = 1'b1;
        end else begin
          s_d.filt = s_q.filt + 6'h01;
        end
      end
      CH_LOCKOUT: begin
        if (s_q.lock >= `CNT_W'(`LOCKOUT_CYCLES - 1)) begin
          s_d.state = CH_RUN;
          s_d.lock = '0;
        end else begin
          s_d.lock = s_q.lock + 16'h0001;
        end
      end
      default: s_d = '0;
    endcase
  end

  // blocked from the fault cycle on, so the bridge drops at once
  assign bridge_blocked = (s_q.state == CH_LOCKOUT) || fault_pulse;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  AST_LOCK_LEN: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.state == CH_LOCKOUT) |-> (s_q.state == CH_LOCKOUT) [*8])
    else $error("lockout ended too early");

  // a fresh indication run of eight cycles is far below the filter time
  sequence cond_fresh;
    !cond ##1 cond [*8];
  endsequence

  AST_NO_QUICK_FAULT: assert property (@(posedge clk) disable iff (rst)
    cond_fresh |-> !fault_pulse)
    else $error("fault raised before the filter time");

  AST_LOCK_END: assert property (@(posedge clk) disable iff (rst)
    $fell(s_q.state == CH_LOCKOUT) |-> ($past(s_q.lock) == `CNT_W'(`LOCKOUT_CYCLES - 1)))
    else $error("lockout ended at the wrong count");

endmodule : bridge_fault_channel

/* File: dual_bridge_drive_control.sv */
// Purpose: decode four inputs into gate commands for two full bridges
// Assumes: inputs and flags synchronous to clk; 20 MHz clock
// Notes: gate outputs are registered enables, one cycle behind inputs
// Notes on behaviour
// - per bridge (1,0) drives p high n low, (0,1) reverse, (1,1) both low, (0,0) both off.
// - high turns on only the source driver, low only the sink, off leaves both off.
// - all inputs low for longer than 1 ms puts the block to sleep.
// - while asleep every gate output of both bridges is off.
// - the undervoltage flag forces every driver off.
// - a source overcurrent on a driver that is on, lasting over 2 us, faults the bridge.
// - a sink overvoltage on a driver that is on, lasting over 2 us, faults the bridge.
// - a fault switches both halves of that bridge off at once.
// - after a fault the bridge ignores its inputs for 2 ms, then retries.
// - fault handling is separate for each bridge.
// - the overtemperature flag disables all gate outputs until it clears.
`timescale 1ns/100ps
`include "bridge_drive_map.svh"

module dual_bridge_drive_control
  import bridge_drive_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bridge_a_fwd_in,
  input wire logic bridge_a_rev_in,
  input wire logic bridge_b_fwd_in,
  input wire logic bridge_b_rev_in,
  input wire logic undervoltage_lock,
  input wire logic overtemp_trip,
  input wire logic bridge_a_src_overcurrent,
  input wire logic bridge_a_snk_overvoltage,
  input wire logic bridge_b_src_overcurrent,
  input wire logic bridge_b_snk_overvoltage,
  output bridge_gates_t bridge_a_gates,
  output bridge_gates_t bridge_b_gates,
  output logic sleeping,
  output logic bridge_a_fault,
  output logic bridge_b_fault
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  function automatic drv_level_t level_of(input logic drive, input logic other);
    if (drive && !other) begin
      level_of = DRV_HIGH;
    end else if (other) begin
      level_of = DRV_LOW;
    end else begin
      level_of = DRV_OFF;
    end
  endfunction : level_of

  function automatic bridge_gates_t decode_bridge(input logic fwd, input logic rev);
    drv_level_t lp;
    drv_level_t ln;
    lp = level_of(fwd, rev);
    ln = level_of(rev, fwd);
    decode_bridge.src_p = (lp == DRV_HIGH);
    decode_bridge.snk_p = (lp == DRV_LOW);
    decode_bridge.src_n = (ln == DRV_HIGH);
    decode_bridge.snk_n = (ln == DRV_LOW);
  endfunction : decode_bridge

  ////////////////////////////////////////////////////////////////////////
  // state

  top_state_t s_q;
  top_state_t s_d;
  logic any_in;
  logic global_off;
  logic block_a;
  logic block_b;

  assign any_in = bridge_a_fwd_in | bridge_a_rev_in | bridge_b_fwd_in | bridge_b_rev_in;
  assign global_off = undervoltage_lock | overtemp_trip;

  // separate channel per bridge
  bridge_fault_channel u_ch_a (
    .clk(clk),
    .rst(rst),
    .src_on(s_q.gates_a.src_p | s_q.gates_a.src_n),
    .snk_on(s_q.gates_a.snk_p | s_q.gates_a.snk_n),
    .src_overcurrent(bridge_a_src_overcurrent),
    .snk_overvoltage(bridge_a_snk_overvoltage),
    .bridge_blocked(block_a),
    .fault_pulse()
  );

  bridge_fault_channel u_ch_b (
    .clk(clk),
    .rst(rst),
    .src_on(s_q.gates_b.src_p | s_q.gates_b.src_n),
    .snk_on(s_q.gates_b.snk_p | s_q.gates_b.snk_n),
    .src_overcurrent(bridge_b_src_overcurrent),
    .snk_overvoltage(bridge_b_snk_overvoltage),
    .bridge_blocked(block_b),
    .fault_pulse()
  );

  always_comb begin
    s_d = s_q;
    if (any_in) begin
      s_d.idle = '0;
      s_d.asleep = 1'b0;
    end else if (s_q.idle >= `CNT_W'(`SLEEP_CYCLES)) begin
      s_d.asleep = 1'b1;
    end else begin
      s_d.idle = s_q.idle + 16'h0001;
    end
    s_d.gates_a = decode_bridge(bridge_a_fwd_in, bridge_a_rev_in);
    s_d.gates_b = decode_bridge(bridge_b_fwd_in, bridge_b_rev_in);
    if (s_d.asleep || global_off) begin
      s_d.gates_a = '0;
      s_d.gates_b = '0;
    end
    if (block_a) begin
      s_d.gates_a = '0;
    end
    if (block_b) begin
      s_d.gates_b = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bridge_a_gates = s_q.gates_a;
  assign bridge_b_gates = s_q.gates_b;
  assign sleeping = s_q.asleep;
  assign bridge_a_fault = block_a;
  assign bridge_b_fault = block_b;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence fwd_a_cmd;
    bridge_a_fwd_in && !bridge_a_rev_in && !global_off && !block_a;
  endsequence

  AST_FWD_DECODE: assert property (@(posedge clk) disable iff (rst)
    fwd_a_cmd |=> (s_q.gates_a == 4'b1001))
    else $error("forward decode wrong");

  AST_BRAKE: assert property (@(posedge clk) disable iff (rst)
    (bridge_b_fwd_in && bridge_b_rev_in && !global_off && !block_b)
    |=> (bridge_b_gates == 4'b0101))
    else $error("brake decode wrong");

  AST_NO_SHOOT: assert property (@(posedge clk) disable iff (rst)
    !(bridge_a_gates.src_p && bridge_a_gates.snk_p)
    && !(bridge_a_gates.src_n && bridge_a_gates.snk_n)
    && !(bridge_b_gates.src_p && bridge_b_gates.snk_p)
    && !(bridge_b_gates.src_n && bridge_b_gates.snk_n))
    else $error("shoot-through on a half bridge");

  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (rst)
    sleeping |-> (bridge_a_gates == '0 && bridge_b_gates == '0))
    else $error("output on while asleep");

  AST_UV_OFF: assert property (@(posedge clk) disable iff (rst)
    undervoltage_lock |=> (bridge_a_gates == '0 && bridge_b_gates == '0))
    else $error("output on under undervoltage");

  AST_OT_OFF: assert property (@(posedge clk) disable iff (rst)
    overtemp_trip |=> (bridge_a_gates == '0 && bridge_b_gates == '0))
    else $error("output on under overtemperature");

  AST_WAKE: assert property (@(posedge clk) disable iff (rst)
    any_in |=> !sleeping)
    else $error("did not wake");

  AST_FAULT_OFF: assert property (@(posedge clk) disable iff (rst)
    $rose(bridge_a_fault) |=> (bridge_a_gates == '0) [*3])
    else $error("bridge a not off after fault");

  AST_NO_EARLY_SLEEP: assert property (@(posedge clk) disable iff (rst)
    any_in |=> !sleeping [*8])
    else $error("slept too early");

  sequence rev_a_cmd;
    !bridge_a_fwd_in && bridge_a_rev_in && !global_off && !block_a;
  endsequence

  sequence fwd_b_cmd;
    bridge_b_fwd_in && !bridge_b_rev_in && !global_off && !block_b;
  endsequence

  AST_REV_DECODE: assert property (@(posedge clk) disable iff (rst)
    rev_a_cmd |=> (bridge_a_gates == 4'h6))
    else $error("reverse decode wrong");

  AST_FWD_DECODE_B: assert property (@(posedge clk) disable iff (rst)
    fwd_b_cmd |=> (bridge_b_gates == 4'h9))
    else $error("bridge b forward decode wrong");

  AST_COAST: assert property (@(posedge clk) disable iff (rst)
    (!bridge_b_fwd_in && !bridge_b_rev_in) |=> (bridge_b_gates == '0))
    else $error("coast decode wrong");

  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (rst)
    (!any_in && s_q.idle >= `CNT_W'(`SLEEP_CYCLES)) |=> sleeping)
    else $error("did not sleep after the idle time");

  AST_IDLE_RESTART: assert property (@(posedge clk) disable iff (rst)
    any_in |=> (s_q.idle == '0))
    else $error("idle count not restarted");

  AST_FAULT_OFF_B: assert property (@(posedge clk) disable iff (rst)
    $rose(bridge_b_fault) |=> (bridge_b_gates == '0) [*3])
    else $error("bridge b not off after fault");

  AST_LOCK_IGNORES: assert property (@(posedge clk) disable iff (rst)
    (bridge_a_fault && bridge_a_fwd_in) |=> (bridge_a_gates == '0))
    else $error("bridge a decoded during lockout");

  // bridge a in fault while bridge b is commanded forward
  sequence a_fault_b_fwd;
    bridge_a_fault ##0 fwd_b_cmd;
  endsequence

  AST_SEPARATE: assert property (@(posedge clk) disable iff (rst)
    a_fault_b_fwd |=> (bridge_b_gates == 4'h9))
    else $error("fault on bridge a disturbed bridge b");

endmodule : dual_bridge_drive_control

/* File: host_drive_model.sv */
// Purpose: host model driving the four command inputs
// Assumes: the bench sets cmd and the mode bits on the falling edge
// Notes: seq_run walks a stepper table, otherwise cmd passes straight through
`timescale 1ns/100ps
module host_drive_model (
  input wire logic clk,
  input wire logic seq_run,
  input wire logic half_step,
  input wire logic [3:0] cmd,
  output logic [3:0] ins
);
  logic [2:0] step_q = 3'h0;
  // half-step order; full step takes every other entry
  logic [3:0] tbl [8] = '{4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8};
  always @(negedge clk) begin
    if (seq_run) begin
      step_q <= step_q + (half_step ? 3'h1 : 3'h2);
    end
  end
  assign ins = seq_run ? tbl[step_q] : cmd;
endmodule : host_drive_model

/* File: tb_dual_bridge_drive_control.sv */
// Purpose: self-checking bench for the dual bridge drive control
// Assumes: counts of 20000, 40 and 40000 cycles at 50 ns
// Notes: inputs change on the falling edge, gates are checked one edge later
`timescale 1ns/100ps
module tb_dual_bridge_drive_control;
  import bridge_drive_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic seq_run = 1'b0;
  logic half_step = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [3:0] ins;
  logic uv = 1'b0;
  logic ot = 1'b0;
  logic [3:0] flt = 4'h0;
  bridge_gates_t ga;
  bridge_gates_t gb;
  logic sleeping;
  logic fa;
  logic fb;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  host_drive_model host (.clk(clk), .seq_run(seq_run), .half_step(half_step),
    .cmd(cmd), .ins(ins));
  dual_bridge_drive_control dut (.clk(clk), .rst(rst), .bridge_a_fwd_in(ins[3]),
    .bridge_a_rev_in(ins[2]), .bridge_b_fwd_in(ins[1]), .bridge_b_rev_in(ins[0]),
    .undervoltage_lock(uv), .overtemp_trip(ot), .bridge_a_src_overcurrent(flt[3]),
    .bridge_a_snk_overvoltage(flt[2]), .bridge_b_src_overcurrent(flt[1]),
    .bridge_b_snk_overvoltage(flt[0]), .bridge_a_gates(ga), .bridge_b_gates(gb),
    .sleeping(sleeping), .bridge_a_fault(fa), .bridge_b_fault(fb));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] enc(input logic [1:0] fr);
    case (fr)
      2'b10: enc = 4'h9;
      2'b01: enc = 4'h6;
      2'b11: enc = 4'h5;
      default: enc = 4'h0;
    endcase
  endfunction : enc
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc_n
  task automatic drive(input logic [3:0] c);
    cmd = c;
    cyc_n(1);
  endtask : drive
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_decode;
    for (int i = 0; i < 16; i++) begin
      drive(i[3:0]);
      chk("gates_a", ga, enc(i[3:2]));
      chk("gates_b", gb, enc(i[1:0]));
    end
    $display("decode test done");
  endtask : test_decode
  task automatic test_seq(input logic half);
    logic [3:0] seen_in;
    half_step <= half;
    seq_run <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      seen_in = ins;
      @(negedge clk);
      chk("step_a", ga, enc(seen_in[3:2]));
      chk("step_b", gb, enc(seen_in[1:0]));
    end
    seq_run <= 1'b0;
    cyc_n(1);
    $display("step test done");
  endtask : test_seq
  task automatic test_flags;
    drive(4'ha);
    uv = 1'b1;
    cyc_n(1);
    chk("uv_off", {ga[3:2], gb[1:0]}, 4'h0);
    uv = 1'b0;
    ot = 1'b1;
    cyc_n(1);
    chk("ot_off", {ga[3:2], gb[1:0]}, 4'h0);
    ot = 1'b0;
    cyc_n(1);
    chk("resume_a", ga, 4'h9);
    $display("flag test done");
  endtask : test_flags
  task automatic test_sleep;
    drive(4'h0);
    cyc_n(19990);
    chk("awake", {3'h0, sleeping}, 4'h0);
    cyc_n(20);
    chk("asleep", {3'h0, sleeping}, 4'h1);
    chk("sleep_off", ga | gb, 4'h0);
    drive(4'h8);
    chk("woken", {3'h0, sleeping}, 4'h0);
    chk("wake_a", ga, 4'h9);
    $display("sleep test done");
  endtask : test_sleep
  task automatic test_fault;
    drive(4'h0);
    flt = 4'hf;
    cyc_n(45);
    chk("idle_a", {3'h0, fa}, 4'h0);
    chk("idle_b", {3'h0, fb}, 4'h0);
    flt = 4'h0;
    drive(4'ha);
    flt = 4'h8;
    cyc_n(20);
    flt = 4'h0;
    cyc_n(2);
    chk("glitch", {3'h0, fa}, 4'h0);
    flt = 4'h8;
    cyc_n(45);
    chk("fault_a", {3'h0, fa}, 4'h1);
    chk("off_a", ga, 4'h0);
    chk("still_b", gb, 4'h9);
    flt = 4'h1;
    cyc_n(45);
    chk("fault_b", {3'h0, fb}, 4'h1);
    chk("off_b", gb, 4'h0);
    flt = 4'h0;
    cyc_n(39800);
    chk("lock_a", ga, 4'h0);
    cyc_n(200);
    chk("retry_a", ga, 4'h9);
    chk("clear_a", {3'h0, fa}, 4'h0);
    chk("retry_b", gb, 4'h9);
    chk("clear_b", {3'h0, fb}, 4'h0);
    flt = 4'h6;
    cyc_n(45);
    chk("sink_fault_a", {3'h0, fa}, 4'h1);
    chk("src_fault_b", {3'h0, fb}, 4'h1);
    chk("off_both", ga | gb, 4'h0);
    flt = 4'h0;
    $display("fault test done");
  endtask : test_fault
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    cyc_n(4);
    rst = 1'b0;
    test_decode;
    test_seq(1'b0);
    test_seq(1'b1);
    test_flags;
    test_sleep;
    test_fault;
    wrap_up;
  end
endmodule : tb_dual_bridge_drive_control
